// ### verilog/adcr_top.sv
// Control and result registers around the successive-approximation converter
// Function
// - A conversion starts after software writes the start bit high, then low.
// - Busy flag rises once a conversion is started; writes to it do nothing.
// - Busy flag falls when the conversion completes.
// - With the converter disabled the result bytes keep their contents.
// - Format zero: result 11..4 in high byte, 3..0 in low byte upper nibble.
// - Format one: result 11..8 in high byte lower nibble, 7..0 in low byte.
// - Result bits not used by the chosen format read zero.
// - Channel codes 0 to 7 pick an analog input; 8 to 15 pick none.
// - Source field picks external channel, supply fractions, amplifier fractions or ground.
// - Any internal source disconnects every external analog input.
// - Conversion clock is system clock divided by two to the field value.
// - Amplifier input is the reference pin or bandgap; bandgap cuts the pin.
// - Reference is supply, reference pin or amplifier; internal choice cuts the pin.
// - Gain field selects gains 1, 1.667, 2.5 and 3.333.
// - Bandgap enable bit switches the bandgap; other bits read zero.
// - Pins used as analog inputs lose their own function and pull-up.
// - A conversion lasts 16 converter clocks: 4 sampling, 12 converting.
// - Conversion completion raises an interrupt request toward the controller.
//
// The register offsets and the plain strobed port were chosen for this implementation.
`include "adcr_params.svh"
`default_nettype none
module adcr_top
    import adcr_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        RST,
    input  wire logic [2:0]  ADDR,
    input  wire logic [7:0]  WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [7:0]  RDATA,
    input  wire logic [11:0] CONV_DATA,
    input  wire logic [7:0]  AN_PIN_SEL,
    output logic             ADC_POWER_EN,
    output logic             ADC_TICK,
    output logic             ADC_SAMPLING,
    output logic      [2:0]  AIN_SRC,
    output logic      [7:0]  AIN_EXT_EN,
    output logic      [7:0]  PIN_FUNC_DIS,
    output logic      [7:0]  PIN_PULLUP_DIS,
    output logic             REF_VDD_EN,
    output logic             REF_PIN_EN,
    output logic             REF_AMP_EN,
    output logic             AMP_EN,
    output logic             AMP_PIN_EN,
    output logic             AMP_BANDGAP_SEL,
    output logic      [1:0]  AMP_GAIN,
    output logic             BANDGAP_EN,
    output logic             CONV_IRQ
);
    adcr_top_st_t st_q;
    adcr_top_st_t st_d;
    logic         trig;
    logic         wr_ctrl0;

    adcr_seq_if seq_if ();

    adcr_sequencer i_adcr_sequencer (
        .CLK (CLK),
        .RST (RST),
        .sq  (seq_if.seq)
    );

    // Input source decode
    function automatic adcr_src_t src_decode(input logic [3:0] ins);
        adcr_src_t s;
        s = SRC_EXT;
        casez (ins)
            4'b0001: s = SRC_VDD;
            4'b0010: s = SRC_VDD2;
            4'b0011: s = SRC_VDD4;
            4'b0101: s = SRC_VR;
            4'b0110: s = SRC_VR2;
            4'b0111: s = SRC_VR4;
            4'b10??: s = SRC_VSS;
            default: s = SRC_EXT;
        endcase
        return s;
    endfunction : src_decode

    // Justified result as high byte then low byte
    function automatic logic [15:0] res_format(input logic [11:0] r, input logic rfs);
        logic [15:0] v;
        if (rfs) begin
            v = {4'h0, r};
        end else begin
            v = {r, 4'h0};
        end
        return v;
    endfunction : res_format

    function automatic logic [7:0] read_mux(input adcr_top_st_t s, input logic [2:0] a);
        logic [15:0] res;
        logic [7:0]  v;
        res = res_format(s.result, s.rfs);
        case (a)
            `ADCR_OFF_RES_LO:  v = res[7:0];
            `ADCR_OFF_RES_HI:  v = res[15:8];
            `ADCR_OFF_CTRL0:   v = {s.start, s.busy, s.en, s.rfs, s.ch};
            `ADCR_OFF_CTRL1:   v = {s.ins, 1'b0, s.cks};
            `ADCR_OFF_REFAMP:  v = {s.amp_en, 2'b00, s.amp_is, s.vrs, s.gain};
            `ADCR_OFF_BANDGAP: v = {7'h00, s.bg_en};
            default:           v = 8'h00;
        endcase
        return v;
    endfunction : read_mux

    function automatic adcr_top_st_t reset_st();
        adcr_top_st_t s;
        logic [7:0]   c1;
        logic [7:0]   ra;
        logic [7:0]   bg;
        s  = '0;
        c1 = `ADCR_RST_CTRL1;
        ra = `ADCR_RST_REFAMP;
        bg = `ADCR_RST_BANDGAP;
        {s.start, s.busy, s.en, s.rfs, s.ch} = `ADCR_RST_CTRL0;
        s.busy = 1'b0;
        {s.ins, s.cks} = {c1[7:4], c1[2:0]};
        {s.amp_en, s.amp_is, s.vrs, s.gain} = {ra[7], ra[4:0]};
        s.bg_en = bg[0];
        return s;
    endfunction : reset_st

    assign wr_ctrl0 = WR && (ADDR == `ADCR_OFF_CTRL0);
    // Start only on the falling write, enabled, not already running
    // Stored enable too: the sequencer is held in abort until it is set
    assign trig = wr_ctrl0 && st_q.start && !WDATA[`ADCR_C0_START]
                  && WDATA[`ADCR_C0_EN] && st_q.en && !st_q.busy;

    assign seq_if.start   = trig;
    assign seq_if.abort   = !st_q.en;
    assign seq_if.div_sel = st_q.cks;

    always_comb begin
        st_d       = st_q;
        st_d.irq   = 1'b0;
        st_d.rdata = 8'h00;
        if (RD) begin
            st_d.rdata = read_mux(st_q, ADDR);
        end
        if (WR) begin
            case (ADDR)
                `ADCR_OFF_CTRL0: begin
                    // Busy bit is not writable
                    st_d.start = WDATA[`ADCR_C0_START];
                    st_d.en    = WDATA[`ADCR_C0_EN];
                    st_d.rfs   = WDATA[`ADCR_C0_RFS];
                    st_d.ch    = WDATA[3:0];
                end
                `ADCR_OFF_CTRL1: begin
                    st_d.ins = WDATA[7:4];
                    st_d.cks = WDATA[2:0];
                end
                `ADCR_OFF_REFAMP: begin
                    st_d.amp_en = WDATA[7];
                    st_d.amp_is = WDATA[4];
                    st_d.vrs    = WDATA[3:2];
                    st_d.gain   = WDATA[1:0];
                end
                `ADCR_OFF_BANDGAP: begin
                    st_d.bg_en = WDATA[0];
                end
                default: begin
                end
            endcase
        end
        if (trig) begin
            st_d.busy = 1'b1;
        end else if (seq_if.done) begin
            st_d.busy = 1'b0;
            if (st_q.en) begin
                st_d.result = CONV_DATA;
                st_d.irq    = 1'b1;
            end
        end else if (!st_q.en) begin
            st_d.busy = 1'b0;
        end
        st_d.src     = src_decode(st_q.ins);
        st_d.ext_en  = 8'h00;
        if (st_q.src == SRC_EXT && !st_q.ch[3]) begin
            st_d.ext_en = 8'h01 << st_q.ch[2:0];
        end
        st_d.pin_dis = AN_PIN_SEL;
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_q <= reset_st();
        end else begin
            st_q <= st_d;
        end
    end

    assign RDATA           = st_q.rdata;
    assign ADC_POWER_EN    = st_q.en;
    assign ADC_TICK        = seq_if.tick;
    assign ADC_SAMPLING    = seq_if.sampling && st_q.busy;
    assign AIN_SRC         = st_q.src;
    assign AIN_EXT_EN      = st_q.ext_en;
    assign PIN_FUNC_DIS    = st_q.pin_dis;
    assign PIN_PULLUP_DIS  = st_q.pin_dis;
    assign REF_VDD_EN      = (st_q.vrs == 2'b00);
    assign REF_PIN_EN      = (st_q.vrs == 2'b01);
    assign REF_AMP_EN      = st_q.vrs[1];
    assign AMP_EN          = st_q.amp_en;
    // Bandgap choice cuts the pin, so both can never drive together
    assign AMP_PIN_EN      = !st_q.amp_is;
    assign AMP_BANDGAP_SEL = st_q.amp_is;
    assign AMP_GAIN        = st_q.gain;
    assign BANDGAP_EN      = st_q.bg_en;
    assign CONV_IRQ        = st_q.irq;

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_start_pulse;
        wr_ctrl0 && WDATA[`ADCR_C0_START] && !st_q.start ##[1:8] trig;
    endsequence
    sequence s_busy_run;
        st_q.busy [*2];
    endsequence

    a_busy_after_start: assert property (s_start_pulse |=> s_busy_run or (st_q.busy ##1 !st_q.en))
        else $error("busy did not follow the start pulse");
    a_busy_cause: assert property ($rose(st_q.busy) |-> $past(trig))
        else $error("busy rose without a start pulse");
    a_done_clears: assert property (seq_if.done && !trig |=> !st_q.busy)
        else $error("busy stayed high after completion");
    a_result_hold: assert property (!st_q.en |=> $stable(st_q.result))
        else $error("result changed while disabled");
    a_left_high: assert property (RD && ADDR == `ADCR_OFF_RES_HI && !st_q.rfs
                                  |=> RDATA == $past(st_q.result[11:4]))
        else $error("left format high byte wrong");
    a_right_low: assert property (RD && ADDR == `ADCR_OFF_RES_LO && st_q.rfs
                                  |=> RDATA == $past(st_q.result[7:0]))
        else $error("right format low byte wrong");
    a_unused_zero: assert property (RD && ADDR == `ADCR_OFF_RES_LO && !st_q.rfs
                                    |=> RDATA[3:0] == 4'h0)
        else $error("unused low nibble not zero");
    a_internal_cut: assert property (st_q.src != SRC_EXT |=> AIN_EXT_EN == 8'h00)
        else $error("external input on with internal source");
    a_no_channel: assert property (st_q.ch[3] |=> AIN_EXT_EN == 8'h00)
        else $error("channel code above seven connected an input");
    a_load_done: assert property (seq_if.done && st_q.en && !trig
                                  |=> st_q.result == $past(CONV_DATA) && !st_q.busy && CONV_IRQ)
        else $error("result, busy and request not together");
    a_irq_cause: assert property (CONV_IRQ |-> $past(seq_if.done))
        else $error("request without completion");
    a_amp_pin: assert property (AMP_BANDGAP_SEL |-> !AMP_PIN_EN)
        else $error("reference pin left on with bandgap");
endmodule : adcr_top
`default_nettype wire

// ### common/adcr_params.svh
// Register offsets, field positions, reset values and timing counts of the converter control block
`ifndef ADCR_PARAMS_SVH
`define ADCR_PARAMS_SVH
`define ADCR_OFF_RES_LO   3'h0
`define ADCR_OFF_RES_HI   3'h1
`define ADCR_OFF_CTRL0    3'h2
`define ADCR_OFF_CTRL1    3'h3
`define ADCR_OFF_REFAMP   3'h4
`define ADCR_OFF_BANDGAP  3'h5
`define ADCR_C0_START     7
`define ADCR_C0_BUSY      6
`define ADCR_C0_EN        5
`define ADCR_C0_RFS       4
`define ADCR_RST_CTRL0    8'h00
`define ADCR_RST_CTRL1    8'h00
`define ADCR_RST_REFAMP   8'h00
`define ADCR_RST_BANDGAP  8'h00
`define ADCR_SAMPLE_TICKS 4'h4
`define ADCR_CONV_TICKS   4'hC
`define ADCR_TOTAL_TICKS  5'h10
`endif

// ### common/adcr_pkg.sv
// Types shared by the converter control modules
`default_nettype none
package adcr_pkg;
    typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONVERT} adcr_seq_state_t;
    typedef enum logic [2:0] {SRC_EXT, SRC_VDD, SRC_VDD2, SRC_VDD4,
                              SRC_VR, SRC_VR2, SRC_VR4, SRC_VSS} adcr_src_t;
    typedef struct packed {
        adcr_seq_state_t state;
        logic [6:0]      div_cnt;
        logic [3:0]      tick_cnt;
        logic            done;
    } adcr_seq_st_t;
    typedef struct packed {
        logic       start;
        logic       en;
        logic       rfs;
        logic [3:0] ch;
        logic [3:0] ins;
        logic [2:0] cks;
        logic       amp_en;
        logic       amp_is;
        logic [1:0] vrs;
        logic [1:0] gain;
        logic       bg_en;
        logic       busy;
        logic [11:0] result;
        logic [7:0] rdata;
        logic       irq;
        adcr_src_t  src;
        logic [7:0] ext_en;
        logic [7:0] pin_dis;
    } adcr_top_st_t;
endpackage : adcr_pkg
`default_nettype wire

// ### common/adcr_seq_if.sv
// Link between the register block and the conversion sequencer
`default_nettype none
interface adcr_seq_if;
    logic       start;
    logic       abort;
    logic [2:0] div_sel;
    logic       tick;
    logic       sampling;
    logic       busy;
    logic       done;
    modport ctl (output start, output abort, output div_sel,
                 input tick, input sampling, input busy, input done);
    modport seq (input start, input abort, input div_sel,
                 output tick, output sampling, output busy, output done);
endinterface : adcr_seq_if
`default_nettype wire

// ### verilog/adcr_sequencer.sv
// Conversion clock divider and sample/convert phase sequencer
`include "adcr_params.svh"
`default_nettype none
module adcr_sequencer
    import adcr_pkg::*;
(
    input wire logic CLK,
    input wire logic RST,
    adcr_seq_if.seq  sq
);
    adcr_seq_st_t st_q;
    adcr_seq_st_t st_d;
    logic [6:0]   lim;

    // Divide by two to the power of the field
    function automatic logic [6:0] div_limit(input logic [2:0] sel);
        logic [7:0] n;
        n = 8'h01 << sel;
        return 7'(n - 8'h01);
    endfunction : div_limit

    assign lim         = div_limit(sq.div_sel);
    assign sq.tick     = (st_q.state != SEQ_IDLE) && (st_q.div_cnt >= lim);
    assign sq.sampling = (st_q.state == SEQ_SAMPLE);
    assign sq.busy     = (st_q.state != SEQ_IDLE);
    assign sq.done     = st_q.done;

    always_comb begin
        st_d      = st_q;
        st_d.done = 1'b0;
        if (st_q.state != SEQ_IDLE) begin
            st_d.div_cnt = sq.tick ? 7'h00 : 7'(st_q.div_cnt + 7'h01);
        end
        case (st_q.state)
            SEQ_IDLE: begin
                if (sq.start) begin
                    st_d.state    = SEQ_SAMPLE;
                    st_d.div_cnt  = 7'h00;
                    st_d.tick_cnt = 4'h0;
                end
            end
            SEQ_SAMPLE: begin
                if (sq.tick) begin
                    st_d.tick_cnt = 4'(st_q.tick_cnt + 4'h1);
                    if (st_q.tick_cnt == 4'(`ADCR_SAMPLE_TICKS - 4'h1)) begin
                        st_d.state    = SEQ_CONVERT;
                        st_d.tick_cnt = 4'h0;
                    end
                end
            end
            SEQ_CONVERT: begin
                if (sq.tick) begin
                    st_d.tick_cnt = 4'(st_q.tick_cnt + 4'h1);
                    if (st_q.tick_cnt == 4'(`ADCR_CONV_TICKS - 4'h1)) begin
                        st_d.state = SEQ_IDLE;
                        st_d.done  = 1'b1;
                    end
                end
            end
            default: st_d.state = SEQ_IDLE;
        endcase
        // Power-down drops a running conversion with no result
        if (sq.abort) begin
            st_d.state = SEQ_IDLE;
            st_d.done  = 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    // Helper: converter ticks since the start
    logic [4:0] ticks_seen;
    always_ff @(posedge CLK) begin
        if (RST || sq.start) begin
            ticks_seen <= 5'h00;
        end else if (sq.tick) begin
            ticks_seen <= 5'(ticks_seen + 5'h01);
        end
    end

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    sequence s_kick;
        !sq.busy && sq.start && !sq.abort;
    endsequence
    sequence s_sample_phase;
        sq.sampling && sq.busy;
    endsequence

    a_start_sampling: assert property (s_kick |=> s_sample_phase)
        else $error("sampling did not begin after start");
    a_total_ticks: assert property (sq.done |-> ticks_seen == `ADCR_TOTAL_TICKS)
        else $error("conversion length is not sixteen ticks");
    a_undivided: assert property (sq.busy && sq.div_sel == 3'h0 |-> sq.tick)
        else $error("undivided clock missed a tick");
    a_div_spacing: assert property (sq.tick && sq.div_sel == 3'h7 && $stable(sq.div_sel)
                                    |=> !sq.tick [*8])
        else $error("divided tick came too early");
endmodule : adcr_sequencer
`default_nettype wire

// ### tb/adcr_conv_model.sv
// Behavioural analog converter that hands over a result only after a full conversion
`default_nettype none
module adcr_conv_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        tick,
    input  wire logic        power,
    input  wire logic [11:0] value,
    output logic      [11:0] conv_data
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [4:0]  tick_cnt;
    logic [11:0] churn;
    always @(posedge clk) begin
        churn <= rst ? 12'h000 : churn + 12'h3A5;
        if (rst || !power) begin
            tick_cnt <= 5'h00;
        end else if (tick) begin
            tick_cnt <= (tick_cnt == 5'h10) ? 5'h01 : tick_cnt + 5'h01;
        end
    end
    // Bits churn until the sixteenth tick and again from the next tick on, so an early sample cannot pass
    assign conv_data = (tick_cnt == 5'h10) ? value : ~value ^ churn;
endmodule : adcr_conv_model
`default_nettype wire

// ### tb/test_adcr_top.sv
// Self-checking bench for the converter control and result registers
`include "adcr_params.svh"
`default_nettype none
module test_adcr_top
    import adcr_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic        clk, rst, wr, rd, power, tick, sampling, vdd_en, pin_en, amp_ref;
    logic        amp_en, amp_pin, amp_bg, bg_en, irq;
    logic [2:0]  addr, src;
    logic [1:0]  gain;
    logic [7:0]  wdata, rdata, pin_sel, ext_en, func_dis, pull_dis;
    logic [11:0] conv_data, value;
    int          miscompares, n_checks, cyc, ticks, sticks, gap, last_tick, irqs;

    adcr_top i_adcr_top (.CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
        .RDATA(rdata), .CONV_DATA(conv_data), .AN_PIN_SEL(pin_sel), .ADC_POWER_EN(power),
        .ADC_TICK(tick), .ADC_SAMPLING(sampling), .AIN_SRC(src), .AIN_EXT_EN(ext_en),
        .PIN_FUNC_DIS(func_dis), .PIN_PULLUP_DIS(pull_dis), .REF_VDD_EN(vdd_en), .REF_PIN_EN(pin_en),
        .REF_AMP_EN(amp_ref), .AMP_EN(amp_en), .AMP_PIN_EN(amp_pin), .AMP_BANDGAP_SEL(amp_bg),
        .AMP_GAIN(gain), .BANDGAP_EN(bg_en), .CONV_IRQ(irq));
    adcr_conv_model i_adcr_conv_model (.clk(clk), .rst(rst), .tick(tick), .power(power),
        .value(value), .conv_data(conv_data));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        if (tick) begin
            ticks++;
            if (sampling) sticks++;
            gap = cyc - last_tick;
            last_tick = cyc;
        end
        if (irq) irqs++;
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : wr_reg

    // Read data stand only in the cycle after the strobe
    task automatic rd_chk(input string what, input logic [2:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk(what, {8'h00, rdata}, {8'h00, exp});
    endtask : rd_chk

    function automatic logic [2:0] exp_src(input logic [3:0] ins);
        case (ins)
            4'h1, 4'h2, 4'h3: return ins[2:0];
            4'h5, 4'h6, 4'h7: return ins[2:0] - 3'h1;
            4'h8, 4'h9, 4'hA, 4'hB: return 3'h7;
            default: return 3'h0;
        endcase
    endfunction : exp_src

    task automatic run_conv(input int k, input logic rfs, input logic [11:0] v);
        ticks  = 0;
        sticks = 0;
        irqs   = 0;
        @(posedge clk);
        value <= v;
        wr_reg(`ADCR_OFF_CTRL1, {5'h00, k[2:0]});
        wr_reg(`ADCR_OFF_CTRL0, {3'h5, rfs, 4'h0});
        wr_reg(`ADCR_OFF_CTRL0, {3'h1, rfs, 4'h0});
        rd_chk("busy set", `ADCR_OFF_CTRL0, {3'h3, rfs, 4'h0});
        for (int i = 0; i < 4000 && irqs == 0; i++) @(posedge clk);
        repeat (3) @(posedge clk);
        #1;
        chk("ticks", 16'(ticks), 16'd16);
        chk("sample ticks", 16'(sticks), 16'd4);
        chk("tick spacing", 16'(gap), 16'(1 << k));
        chk("irq count", 16'(irqs), 16'd1);
        rd_chk("busy clear", `ADCR_OFF_CTRL0, {3'h1, rfs, 4'h0});
        rd_chk("result high", `ADCR_OFF_RES_HI, rfs ? {4'h0, v[11:8]} : v[11:4]);
        rd_chk("result low", `ADCR_OFF_RES_LO, rfs ? v[7:0] : {v[3:0], 4'h0});
    endtask : run_conv

    initial begin
        repeat (30000) @(posedge clk);
        miscompares++;
        give_verdict();
    end

    initial begin
        rst = 1'b1;
        wr = 1'b0;
        rd = 1'b0;
        addr = 3'h0;
        wdata = 8'h00;
        pin_sel = 8'h00;
        value = 12'h000;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        for (int a = 0; a < 8; a++) rd_chk("reset value", 3'(a), 8'h00);
        chk("reset decode", {13'h0, vdd_en, amp_pin, power}, 16'h0006);
        wr_reg(`ADCR_OFF_CTRL1, 8'hFF);
        rd_chk("ctrl1 mask", `ADCR_OFF_CTRL1, 8'hF7);
        wr_reg(`ADCR_OFF_BANDGAP, 8'hFF);
        rd_chk("bandgap mask", `ADCR_OFF_BANDGAP, 8'h01);
        chk("bandgap on", {15'h0, bg_en}, 16'h0001);
        // Bandgap already on before the amplifier takes it as input
        wr_reg(`ADCR_OFF_REFAMP, 8'hFF);
        rd_chk("refamp mask", `ADCR_OFF_REFAMP, 8'h9F);
        wr_reg(`ADCR_OFF_REFAMP, 8'h00);
        wr_reg(`ADCR_OFF_BANDGAP, 8'h00);
        #1;
        chk("bandgap off", {15'h0, bg_en}, 16'h0000);
        wr_reg(3'h6, 8'hFF);
        rd_chk("unmapped", 3'h6, 8'h00);
        // Every source code against an in-range and an out-of-range channel
        for (int i = 0; i < 32; i++) begin
            wr_reg(`ADCR_OFF_CTRL1, {4'(i), 4'h0});
            wr_reg(`ADCR_OFF_CTRL0, {4'h2, i[4] ? 4'h9 : 4'h3});
            repeat (3) @(posedge clk);
            #1;
            chk("source", {13'h0, src}, {13'h0, exp_src(4'(i))});
            chk("ext switch", {8'h00, ext_en}, {8'h00, (exp_src(4'(i)) == 3'h0 && !i[4]) ? 8'h08 : 8'h00});
            chk("power", {15'h0, power}, 16'h0001);
        end
        wr_reg(`ADCR_OFF_BANDGAP, 8'h01);
        for (int i = 0; i < 16; i++) begin
            wr_reg(`ADCR_OFF_REFAMP, {i[3], 2'h0, i[3], 4'(i)});
            repeat (2) @(posedge clk);
            #1;
            chk("reference", {13'h0, vdd_en, pin_en, amp_ref}, {13'h0, i[3:2] == 2'h0, i[3:2] == 2'h1, i[3]});
            chk("amp", {11'h0, amp_en, amp_pin, amp_bg, gain}, {11'h0, i[3], !i[3], i[3], 2'(i)});
        end
        wr_reg(`ADCR_OFF_REFAMP, 8'h00);
        @(posedge clk);
        pin_sel <= 8'hA5;
        repeat (2) @(posedge clk);
        #1;
        chk("pin function", {func_dis, pull_dis}, 16'hA5A5);
        for (int k = 0; k < 8; k++) run_conv(k, k[0], 12'h5A3 + 12'(k) * 12'h111);
        // Clearing the enable in mid-conversion leaves the old result and no request
        ticks = 0;
        irqs = 0;
        @(posedge clk);
        value <= 12'h123;
        wr_reg(`ADCR_OFF_CTRL0, 8'hA0);
        wr_reg(`ADCR_OFF_CTRL0, 8'h20);
        repeat (3) @(posedge clk);
        wr_reg(`ADCR_OFF_CTRL0, 8'h00);
        rd_chk("busy after abort", `ADCR_OFF_CTRL0, 8'h00);
        repeat (40) @(posedge clk);
        #1;
        chk("irq after abort", 16'(irqs), 16'd0);
        rd_chk("held high", `ADCR_OFF_RES_HI, 8'hD1);
        rd_chk("held low", `ADCR_OFF_RES_LO, 8'hA0);
        wr_reg(`ADCR_OFF_CTRL0, 8'h80);
        wr_reg(`ADCR_OFF_CTRL0, 8'h10);
        rd_chk("start while off", `ADCR_OFF_CTRL0, 8'h10);
        rd_chk("held high right", `ADCR_OFF_RES_HI, 8'h0D);
        rd_chk("held low right", `ADCR_OFF_RES_LO, 8'h1A);
        wr_reg(`ADCR_OFF_CTRL0, 8'h40);
        rd_chk("busy write", `ADCR_OFF_CTRL0, 8'h00);
        give_verdict();
    end
endmodule : test_adcr_top
`default_nettype wire
